// ==== verilog/pulse_template_pkg.sv ====
package pulse_template_pkg;

   // Channel layout of the register map
   localparam int CHAN_COUNT = 8;
   localparam int CHAN_BITS = 3;
   localparam logic [7:0] CHAN_STRIDE = 8'h20;
   localparam logic [4:0] OFS_AMPLITUDE_SCALE = 5'h04;
   localparam logic [4:0] OFS_ACCESS_CONTROL = 5'h05;
   localparam logic [4:0] OFS_SAMPLE_DATA = 5'h06;

   // Field positions of the amplitude scale register
   localparam int SCALE_MSB = 5;
   localparam int SCALE_LSB = 0;
   localparam logic [5:0] SCALE_RESET = 6'h21;

   // Field positions of the access control register
   localparam int CTRL_TRIGGER_BIT = 7;
   localparam int CTRL_DIR_BIT = 6;
   localparam int CTRL_INTERVAL_MSB = 5;
   localparam int CTRL_INTERVAL_LSB = 4;
   localparam int CTRL_SAMPLE_MSB = 3;
   localparam int CTRL_SAMPLE_LSB = 0;
   localparam logic CTRL_TRIGGER_RESET = 1'b0;
   localparam logic CTRL_DIR_RESET = 1'b0;
   localparam logic [1:0] CTRL_INTERVAL_RESET = 2'h0;
   localparam logic [3:0] CTRL_SAMPLE_RESET = 4'h0;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;

   // Field positions of the sample data register
   localparam int DATA_MSB = 6;
   localparam int DATA_LSB = 0;
   localparam logic [6:0] DATA_RESET = 7'h00;

   // Template RAM geometry
   localparam int INTERVAL_COUNT = 4;
   localparam int SAMPLES_PER_INTERVAL = 16;
   localparam int RAM_DEPTH = CHAN_COUNT * INTERVAL_COUNT * SAMPLES_PER_INTERVAL;
   localparam int RAM_ADDR_BITS = 9;
   localparam int AMP_BITS = 7;

   // Default scale codes per build-out class
   localparam logic [5:0] SCALE_DEF_T1_SHORT = 6'h36;
   localparam logic [5:0] SCALE_DEF_DS1_M7P5 = 6'h11;
   localparam logic [5:0] SCALE_DEF_DS1_M15 = 6'h08;
   localparam logic [5:0] SCALE_DEF_DS1_M22P5 = 6'h04;
   localparam logic [5:0] SCALE_DEF_E1 = 6'h21;

   // Amplitude change per code step, in hundredths of a percent
   localparam int STEP_BITS = 12;
   localparam logic [11:0] STEP_T1_SHORT = 12'h0c8;
   localparam logic [11:0] STEP_DS1_M7P5 = 12'h271;
   localparam logic [11:0] STEP_DS1_M15 = 12'h4e2;
   localparam logic [11:0] STEP_DS1_M22P5 = 12'h9c4;
   localparam logic [11:0] STEP_E1 = 12'h12c;

   // Transmit template select codes
   localparam logic [3:0] TPL_E1_75_INTERNAL = 4'h0;
   localparam logic [3:0] TPL_E1_75_EXTERNAL = 4'h1;
   localparam logic [3:0] TPL_DSX1_FIRST = 4'h2;
   localparam logic [3:0] TPL_DS1_0DB = 4'h8;
   localparam logic [3:0] TPL_DS1_M7P5 = 4'h9;
   localparam logic [3:0] TPL_DS1_M15 = 4'ha;
   localparam logic [3:0] TPL_DS1_M22P5 = 4'hb;

   // Access engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_CAPTURE = 2'b10
   } access_state_t;

   // Lowest set bit of a pending vector
   function automatic logic [2:0] lowest_pending(input logic [7:0] vec);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = CHAN_COUNT - 1; i >= 0; i--) begin
         if (vec[i]) begin
            idx = i[2:0];
         end
      end
      return idx;
   endfunction : lowest_pending

   // Template RAM word address from channel, interval and sample
   function automatic logic [8:0] ram_address(input logic [2:0] chan, input logic [1:0] interval,
                                              input logic [3:0] slot);
      return {chan, interval, slot};
   endfunction : ram_address

endpackage : pulse_template_pkg

// ==== verilog/pulse_template_ram.sv ====
`timescale 1ns/1ps
module pulse_template_ram
   import pulse_template_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Access port from the register side
   input wire logic i_acc_wr_en,
   input wire logic [8:0] i_acc_addr,
   input wire logic [6:0] i_acc_wdata,
   output logic [6:0] o_acc_rdata,
   // Playback port for the waveform shaper
   input wire logic [8:0] i_play_addr,
   output logic [6:0] o_play_rdata
);

   logic [6:0] mem [0:RAM_DEPTH-1];

   // Write port and two registered read ports
   always_ff @(posedge i_clk) begin
      if (i_acc_wr_en) begin
         mem[i_acc_addr] <= i_acc_wdata;
      end
      o_acc_rdata <= mem[i_acc_addr];
      o_play_rdata <= mem[i_play_addr];
   end

endmodule : pulse_template_ram

// ==== verilog/amplitude_step_lookup.sv ====
`timescale 1ns/1ps
module amplitude_step_lookup
   import pulse_template_pkg::*;
(
   // Template selected by the transmit configuration
   input wire logic [3:0] i_template_select,
   // Recommended scale code and its step size
   output logic [5:0] o_default_scale,
   output logic [11:0] o_step_size
);

   // Build-out class decode; user templates fall back to the E1 default
   always_comb begin
      o_default_scale = SCALE_DEF_E1;
      o_step_size = STEP_E1;
      if (i_template_select >= TPL_DSX1_FIRST && i_template_select <= TPL_DS1_0DB) begin
         o_default_scale = SCALE_DEF_T1_SHORT;
         o_step_size = STEP_T1_SHORT;
      end else if (i_template_select == TPL_DS1_M7P5) begin
         o_default_scale = SCALE_DEF_DS1_M7P5;
         o_step_size = STEP_DS1_M7P5;
      end else if (i_template_select == TPL_DS1_M15) begin
         o_default_scale = SCALE_DEF_DS1_M15;
         o_step_size = STEP_DS1_M15;
      end else if (i_template_select == TPL_DS1_M22P5) begin
         o_default_scale = SCALE_DEF_DS1_M22P5;
         o_step_size = STEP_DS1_M22P5;
      end
   end

endmodule : amplitude_step_lookup

// ==== verilog/pulse_template_access.sv ====
`timescale 1ns/1ps
module pulse_template_access
   import pulse_template_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Control register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Template selects of the eight channels, four bits each
   input wire logic [31:0] i_transmit_template_select,
   // Waveform shaper playback port
   input wire logic [2:0] i_play_chan,
   input wire logic [1:0] i_play_interval,
   input wire logic [3:0] i_play_sample,
   output logic [6:0] o_play_amplitude,
   // Per-channel results, six, twelve or one bit per channel
   output logic [47:0] o_amplitude_scale,
   output logic [47:0] o_default_scale,
   output logic [95:0] o_scale_step,
   output logic [7:0] o_access_busy
);

   // Register state
   logic [7:0][5:0] amplitude_scale_r;
   logic [7:0][5:0] amplitude_scale_nxt;
   logic [7:0] trigger_r;
   logic [7:0] trigger_nxt;
   logic [7:0] direction_r;
   logic [7:0] direction_nxt;
   logic [7:0][1:0] interval_index_r;
   logic [7:0][1:0] interval_index_nxt;
   logic [7:0][3:0] sample_index_r;
   logic [7:0][3:0] sample_index_nxt;
   logic [7:0][6:0] sample_amplitude_r;
   logic [7:0][6:0] sample_amplitude_nxt;
   logic [7:0] reg_rdata_r;
   logic [7:0] reg_rdata_nxt;
   logic reg_rvalid_r;

   // Access engine state
   access_state_t state_r;
   access_state_t state_nxt;
   logic [2:0] sel_chan_r;
   logic [2:0] sel_chan_nxt;

   // Recommended scale code and step per channel, before and after the flops
   wire logic [7:0][5:0] lookup_scale;
   wire logic [7:0][11:0] lookup_step;
   logic [7:0][5:0] default_scale_r;
   logic [7:0][11:0] scale_step_r;

   // Address decode wires
   wire logic [2:0] addr_chan;
   wire logic [4:0] addr_offset;
   wire logic hit_scale;
   wire logic hit_ctrl;
   wire logic hit_data;
   wire logic [7:0] chan_onehot;
   wire logic [7:0] wr_scale;
   wire logic [7:0] wr_ctrl;
   wire logic [7:0] wr_data;

   // Engine wires
   wire logic [7:0] clear_trigger;
   wire logic capture_valid;
   wire logic ram_wr_en;
   wire logic [8:0] ram_acc_addr;
   wire logic [8:0] ram_play_addr;
   wire logic [6:0] ram_acc_rdata;
   wire logic [6:0] ram_play_rdata;

   // Channel copies sit at a fixed stride; the low five bits pick the register
   assign addr_chan = i_reg_addr[7:5];
   assign addr_offset = i_reg_addr[4:0];
   assign hit_scale = (addr_offset == OFS_AMPLITUDE_SCALE);
   assign hit_ctrl = (addr_offset == OFS_ACCESS_CONTROL);
   assign hit_data = (addr_offset == OFS_SAMPLE_DATA);
   assign chan_onehot = 8'h01 << addr_chan;
   assign wr_scale = (i_reg_wr_en && hit_scale) ? chan_onehot : 8'h00;
   assign wr_ctrl = (i_reg_wr_en && hit_ctrl) ? chan_onehot : 8'h00;
   assign wr_data = (i_reg_wr_en && hit_data) ? chan_onehot : 8'h00;

   // RAM address comes from the selected channel's control fields
   assign ram_acc_addr = ram_address(sel_chan_r, interval_index_r[sel_chan_r],
                                     sample_index_r[sel_chan_r]);
   assign ram_play_addr = ram_address(i_play_chan, i_play_interval, i_play_sample);
   assign ram_wr_en = (state_r == ST_ISSUE) && (direction_r[sel_chan_r] == DIR_WRITE);
   assign capture_valid = (state_r == ST_CAPTURE);

   // Trigger clears after a write issues or a read captures
   assign clear_trigger = (ram_wr_en || capture_valid) ? (8'h01 << sel_chan_r) : 8'h00;

   // Register next values
   always_comb begin
      amplitude_scale_nxt = amplitude_scale_r;
      trigger_nxt = trigger_r;
      direction_nxt = direction_r;
      interval_index_nxt = interval_index_r;
      sample_index_nxt = sample_index_r;
      sample_amplitude_nxt = sample_amplitude_r;
      for (int c = 0; c < CHAN_COUNT; c++) begin
         if (wr_scale[c]) begin
            amplitude_scale_nxt[c] = i_reg_wdata[SCALE_MSB:SCALE_LSB];
         end
         if (wr_ctrl[c]) begin
            direction_nxt[c] = i_reg_wdata[CTRL_DIR_BIT];
            interval_index_nxt[c] = i_reg_wdata[CTRL_INTERVAL_MSB:CTRL_INTERVAL_LSB];
            sample_index_nxt[c] = i_reg_wdata[CTRL_SAMPLE_MSB:CTRL_SAMPLE_LSB];
         end
         // A new trigger in the clearing cycle is kept
         trigger_nxt[c] = (wr_ctrl[c] && i_reg_wdata[CTRL_TRIGGER_BIT]) ||
                          (trigger_r[c] && !clear_trigger[c]);
         if (wr_data[c]) begin
            sample_amplitude_nxt[c] = i_reg_wdata[DATA_MSB:DATA_LSB];
         end
      end
      // Read-back data wins over a software write in the same cycle
      if (capture_valid) begin
         sample_amplitude_nxt[sel_chan_r] = ram_acc_rdata;
      end
   end

   // Access engine: pick a pending channel, issue, then capture on reads
   always_comb begin
      state_nxt = state_r;
      sel_chan_nxt = sel_chan_r;
      case (state_r)
         ST_IDLE: begin
            if (|trigger_r) begin
               sel_chan_nxt = lowest_pending(trigger_r);
               state_nxt = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            if (direction_r[sel_chan_r] == DIR_READ) begin
               state_nxt = ST_CAPTURE;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         ST_CAPTURE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Read data mux; reserved bits and unmapped offsets read as zero
   always_comb begin
      reg_rdata_nxt = 8'h00;
      if (hit_scale) begin
         reg_rdata_nxt = {2'h0, amplitude_scale_r[addr_chan]};
      end else if (hit_ctrl) begin
         reg_rdata_nxt = {trigger_r[addr_chan], direction_r[addr_chan], interval_index_r[addr_chan],
                          sample_index_r[addr_chan]};
      end else if (hit_data) begin
         reg_rdata_nxt = {1'b0, sample_amplitude_r[addr_chan]};
      end
   end

   // Amplitude scale flops
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         amplitude_scale_r <= {CHAN_COUNT{SCALE_RESET}};
      end else begin
         amplitude_scale_r <= amplitude_scale_nxt;
      end
   end

   // Access control flops; the trigger bit doubles as the busy flag
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         trigger_r <= {CHAN_COUNT{CTRL_TRIGGER_RESET}};
         direction_r <= {CHAN_COUNT{CTRL_DIR_RESET}};
         interval_index_r <= {CHAN_COUNT{CTRL_INTERVAL_RESET}};
         sample_index_r <= {CHAN_COUNT{CTRL_SAMPLE_RESET}};
      end else begin
         trigger_r <= trigger_nxt;
         direction_r <= direction_nxt;
         interval_index_r <= interval_index_nxt;
         sample_index_r <= sample_index_nxt;
      end
   end

   // Sample data flops; the template RAM itself keeps no reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sample_amplitude_r <= {CHAN_COUNT{DATA_RESET}};
      end else begin
         sample_amplitude_r <= sample_amplitude_nxt;
      end
   end

   // Recommendations leave from flops; reset matches the all-zero template select
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         default_scale_r <= {CHAN_COUNT{SCALE_DEF_E1}};
         scale_step_r <= {CHAN_COUNT{STEP_E1}};
      end else begin
         default_scale_r <= lookup_scale;
         scale_step_r <= lookup_step;
      end
   end

   // Engine and read port flops
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_r <= ST_IDLE;
         sel_chan_r <= 3'h0;
         reg_rdata_r <= 8'h00;
         reg_rvalid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sel_chan_r <= sel_chan_nxt;
         reg_rvalid_r <= i_reg_rd_en;
         if (i_reg_rd_en) begin
            reg_rdata_r <= reg_rdata_nxt;
         end
      end
   end

   // Shared template RAM for all channels
   pulse_template_ram u_ram (
      .i_clk(i_clk),
      .i_acc_wr_en(ram_wr_en),
      .i_acc_addr(ram_acc_addr),
      .i_acc_wdata(sample_amplitude_r[sel_chan_r]),
      .o_acc_rdata(ram_acc_rdata),
      .i_play_addr(ram_play_addr),
      .o_play_rdata(ram_play_rdata)
   );

   // Default scale and step size per channel from its template select
   for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_lookup
      amplitude_step_lookup u_lookup (
         .i_template_select(i_transmit_template_select[4*g +: 4]),
         .o_default_scale(lookup_scale[g]),
         .o_step_size(lookup_step[g])
      );
      assign o_amplitude_scale[6*g +: 6] = amplitude_scale_r[g];
   end

   // Output drives
   assign o_reg_rdata = reg_rdata_r;
   assign o_reg_rvalid = reg_rvalid_r;
   assign o_play_amplitude = ram_play_rdata;
   assign o_default_scale = default_scale_r;
   assign o_scale_step = scale_step_r;
   assign o_access_busy = trigger_r;

endmodule : pulse_template_access

// ==== tb/pulse_template_access_asserts.sv ====
`timescale 1ns/1ps
module template_access_checker
   import pulse_template_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   // Template selects and results
   input wire logic [31:0] i_transmit_template_select,
   input wire logic [47:0] o_amplitude_scale,
   input wire logic [47:0] o_default_scale,
   input wire logic [95:0] o_scale_step,
   input wire logic [7:0] o_access_busy
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // Decoded register writes
   wire scale_wr = i_reg_wr_en && (i_reg_addr[4:0] == OFS_AMPLITUDE_SCALE);
   wire trig_wr = i_reg_wr_en && (i_reg_addr[4:0] == OFS_ACCESS_CONTROL) && i_reg_wdata[7];

   // Read answer timing and content
   chk_read_answer_one: assert property (i_reg_rd_en |=> o_reg_rvalid) else $error("read not answered");
   chk_rvalid_needs_read: assert property (o_reg_rvalid |-> $past(i_reg_rd_en)) else $error("stray rvalid");
   chk_rdata_holds: assert property (!o_reg_rvalid && !$past(i_sys_rst) |-> $stable(o_reg_rdata))
      else $error("rdata moved");
   chk_scale_reserved_zero: assert property (o_reg_rvalid && $past(i_reg_addr[4:0]) == OFS_AMPLITUDE_SCALE
      |-> o_reg_rdata[7:6] == 2'h0) else $error("scale reserved bits set");
   // Scale register follows writes only
   chk_scale_write_lands: assert property (scale_wr |=> o_amplitude_scale[6*$past(i_reg_addr[7:5]) +: 6]
      == $past(i_reg_wdata[5:0])) else $error("scale write lost");
   chk_scale_no_write: assert property (!scale_wr |=> $stable(o_amplitude_scale)) else $error("scale drift");
   // Trigger launches an access; on channel zero it ends in bounded time
   chk_trigger_sets_busy: assert property (trig_wr |=> o_access_busy[$past(i_reg_addr[7:5])])
      else $error("trigger not seen");
   chk_busy_clears: assert property ($rose(o_access_busy[0]) |-> ##[1:40] !o_access_busy[0])
      else $error("access never done");
   // Default scale codes of channel zero, one cycle after the select
   chk_default_e1: assert property (i_transmit_template_select[3:0] == 4'h0
      |=> o_default_scale[5:0] == 6'h21 && o_scale_step[11:0] == 12'h12c) else $error("e1 default");
   chk_default_ds1_low: assert property (i_transmit_template_select[3:0] == 4'hb
      |=> o_default_scale[5:0] == 6'h04 && o_scale_step[11:0] == 12'h9c4) else $error("ds1 default");

   // Main scenarios
   cov_trigger: cover property (trig_wr);
   cov_scale_write: cover property (scale_wr);
   cov_read: cover property (o_reg_rvalid);
endmodule : template_access_checker

bind pulse_template_access template_access_checker u_template_access_checker (.i_clk, .i_sys_rst,
   .i_reg_addr, .i_reg_wr_en, .i_reg_rd_en, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
   .i_transmit_template_select, .o_amplitude_scale, .o_default_scale, .o_scale_step, .o_access_busy);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;
   import pulse_template_pkg::*;
   logic i_clk, i_sys_rst, i_reg_wr_en, i_reg_rd_en;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_access_busy;
   logic o_reg_rvalid;
   logic [31:0] i_transmit_template_select;
   logic [2:0] i_play_chan;
   logic [1:0] i_play_interval;
   logic [3:0] i_play_sample;
   logic [6:0] o_play_amplitude;
   logic [47:0] o_amplitude_scale, o_default_scale;
   logic [95:0] o_scale_step;
   int fails = 0;
   int total_checks = 0;
   logic [7:0] rv;

   pulse_template_access u_pulse_template_access (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_reg_addr(i_reg_addr), .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_transmit_template_select(i_transmit_template_select), .i_play_chan(i_play_chan),
      .i_play_interval(i_play_interval), .i_play_sample(i_play_sample),
      .o_play_amplitude(o_play_amplitude), .o_amplitude_scale(o_amplitude_scale),
      .o_default_scale(o_default_scale), .o_scale_step(o_scale_step), .o_access_busy(o_access_busy));

   // Clock generation
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1 i_reg_wr_en = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(posedge i_clk);
      #1 i_reg_wr_en = 1'b0;
   endtask : wr

   // Register read, answer one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1 i_reg_rd_en = 1'b1;
      i_reg_addr = a;
      @(posedge i_clk);
      #1 i_reg_rd_en = 1'b0;
      `CHK(o_reg_rvalid, 1'b1)
      d = o_reg_rdata;
   endtask : rd

   // Poll the trigger bit until the access is done
   task automatic wait_done(input logic [2:0] ch);
      logic [7:0] c;
      c = 8'h80;
      for (int i = 0; i < 20 && c[7] !== 1'b0; i++) rd({ch, OFS_ACCESS_CONTROL}, c);
      `CHK(c[7], 1'b0)
   endtask : wait_done

   // Indirect template write and read
   task automatic tpl_wr(input logic [2:0] ch, input logic [1:0] iv, input logic [3:0] s, input logic [6:0] v);
      logic [7:0] c;
      wr({ch, OFS_SAMPLE_DATA}, {1'b0, v});
      wr({ch, OFS_ACCESS_CONTROL}, {2'b10, iv, s});
      `CHK(o_access_busy[ch], 1'b1)
      wait_done(ch);
      `CHK(o_access_busy, 8'h00)
      rd({ch, OFS_ACCESS_CONTROL}, c);
      `CHK(c, {2'b00, iv, s})
   endtask : tpl_wr

   // Data register is preloaded with the inverse so a lost capture shows
   task automatic tpl_rd(input logic [2:0] ch, input logic [1:0] iv, input logic [3:0] s, input logic [6:0] v);
      logic [7:0] d;
      wr({ch, OFS_SAMPLE_DATA}, {1'b0, ~v});
      wr({ch, OFS_ACCESS_CONTROL}, {2'b11, iv, s});
      wait_done(ch);
      rd({ch, OFS_SAMPLE_DATA}, d);
      `CHK(d, {1'b0, v})
      @(posedge i_clk);
      #1 i_play_chan = ch;
      i_play_interval = iv;
      i_play_sample = s;
      @(posedge i_clk);
      @(posedge i_clk);
      #1 `CHK(o_play_amplitude, v)
   endtask : tpl_rd

   // Expected default code and step for a template select
   function automatic logic [17:0] exp_def(input logic [3:0] t);
      if (t == 4'h9) return {6'h11, 12'h271};
      if (t == 4'ha) return {6'h08, 12'h4e2};
      if (t == 4'hb) return {6'h04, 12'h9c4};
      if (t >= 4'h2 && t <= 4'h8) return {6'h36, 12'h0c8};
      return {6'h21, 12'h12c};
   endfunction : exp_def

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // Watchdog
   initial begin
      #200000;
      fails++;
      tally_and_finish;
   end

   // Test sequence
   initial begin
      i_sys_rst = 1'b1;
      {i_reg_wr_en, i_reg_rd_en, i_reg_addr, i_reg_wdata} = '0;
      i_transmit_template_select = '0;
      {i_play_chan, i_play_interval, i_play_sample} = '0;
      repeat (5) @(posedge i_clk);
      #1 i_sys_rst = 1'b0;
      // Reset values and unmapped offsets
      rd(8'h04, rv);
      `CHK(rv, 8'h21)
      rd(8'he4, rv);
      `CHK(rv, 8'h21)
      rd(8'h05, rv);
      `CHK(rv, 8'h00)
      rd(8'h07, rv);
      `CHK(rv, 8'h00)
      `CHK(o_amplitude_scale, {8{6'h21}})
      `CHK(o_default_scale, {8{6'h21}})
      `CHK(o_access_busy, 8'h00)
      $display("test reset done");
      // Scale writes with reserved bits, stride per channel
      wr(8'h64, 8'hff);
      rd(8'h64, rv);
      `CHK(rv, 8'h3f)
      `CHK(o_amplitude_scale[18 +: 6], 6'h3f)
      wr(8'he4, 8'h36);
      rd(8'he4, rv);
      `CHK(rv, 8'h36)
      wr(8'h01, 8'hff);
      rd(8'h01, rv);
      `CHK(rv, 8'h00)
      wr(8'h06, 8'hff);
      rd(8'h06, rv);
      `CHK(rv, 8'h7f)
      $display("test scale done");
      // Default code and step for every template select, one cycle after the select
      for (int t = 0; t < 16; t++) begin
         @(posedge i_clk);
         #1 i_transmit_template_select = {8{t[3:0]}};
         @(posedge i_clk);
         #1 `CHK({o_default_scale[5:0], o_scale_step[11:0]}, exp_def(t[3:0]))
         `CHK({o_default_scale[35:30], o_scale_step[71:60]}, exp_def(t[3:0]))
      end
      // E1 on 75 ohm with internal matching uses the all-zero template
      @(posedge i_clk);
      #1 i_transmit_template_select = {8{TPL_E1_75_INTERNAL}};
      @(posedge i_clk);
      #1 `CHK({o_default_scale[47:42], o_scale_step[95:84]}, {6'h21, 12'h12c})
      $display("test defaults done");
      // Indirect template RAM writes at the corners, then read back
      tpl_wr(3'd0, 2'd0, 4'h0, 7'h7f);
      tpl_wr(3'd0, 2'd3, 4'hf, 7'h00);
      tpl_wr(3'd7, 2'd2, 4'h9, 7'h55);
      tpl_wr(3'd4, 2'd1, 4'h0, 7'h2a);
      tpl_wr(3'd4, 2'd1, 4'h1, 7'h15);
      tpl_rd(3'd0, 2'd0, 4'h0, 7'h7f);
      tpl_rd(3'd0, 2'd3, 4'hf, 7'h00);
      tpl_rd(3'd7, 2'd2, 4'h9, 7'h55);
      tpl_rd(3'd4, 2'd1, 4'h0, 7'h2a);
      tpl_rd(3'd4, 2'd1, 4'h1, 7'h15);
      $display("test template done");
      // Mid-run reset restores registers
      @(posedge i_clk);
      #1 i_sys_rst = 1'b1;
      @(posedge i_clk);
      #1 i_sys_rst = 1'b0;
      rd(8'h64, rv);
      `CHK(rv, 8'h21)
      $display("test rereset done");
      tally_and_finish;
   end
endmodule : tb
